// ==== rtl/adc_pkg.sv ====
/*
 * Constants, types and decode functions shared by the converter control.
 * Assumes one converter clock; all control bits arrive synchronous to it.
 */
package adc_pkg;
	localparam int unsigned RES_W = 10;
	localparam int unsigned NCH = 8;
	localparam int unsigned FIFO_W = 16;
	localparam int unsigned FIFO_DEPTH = 16;
	localparam int unsigned CNT_W = 6;
	// conversion lengths in converter clock cycles
	localparam logic [5:0] CYC_SH_8 = 6'h1C;
	localparam logic [5:0] CYC_SH_10 = 6'h21;
	localparam logic [5:0] CYC_NOSH_8 = 6'h2F;
	localparam logic [5:0] CYC_NOSH_10 = 6'h39;
	// operating modes
	localparam logic [1:0] MODE_ONESHOT = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] MODE_SINGLE = 2'h2;
	localparam logic [1:0] MODE_RSWEEP = 2'h3;
	// extended input select field
	localparam logic [1:0] EXT_NONE = 2'h0;
	localparam logic [1:0] EXT_A = 2'h1;
	localparam logic [1:0] EXT_B = 2'h2;
	localparam logic [1:0] EXT_OPAMP = 2'h3;
	// analog source select codes and result register index values
	localparam logic [3:0] SRC_EXT_A = 4'h8;
	localparam logic [3:0] SRC_EXT_B = 4'h9;
	localparam logic [2:0] IDX_ZERO = 3'h0;
	localparam logic [2:0] IDX_ONE = 3'h1;

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_WAIT = 3'b010,
		S_CONV = 3'b100
	} state_t;

	// last count value of one conversion
	function automatic logic [5:0] conv_last(input logic sh,
		input logic res10);
		logic [5:0] cyc;
		cyc = sh ? (res10 ? CYC_SH_10 : CYC_SH_8) :
			(res10 ? CYC_NOSH_10 : CYC_NOSH_8);
		return cyc - 6'h01;
	endfunction
endpackage

// ==== rtl/stream_if.sv ====
/*
 * Valid/ready word stream between the converter control and its FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface stream_if #(parameter int W = 16);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/adc_trig_detect.sv ====
/*
 * Hardware trigger source: falling edge of the trigger pin or timer event.
 * Assumes the pin and the timer event are synchronous to mclk_in.
 */
`timescale 1ns/1ps
module adc_trig_detect (
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// sources
	input wire logic ext_trigger_pin_in,
	input wire logic motor_timer_evt_in,
	input wire logic hw_source_select_in,
	// event
	output logic trig_evt_out
);
	logic pin_q_ff;
	wire logic pin_fall;

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			pin_q_ff <= 1'b1;
		end else if (ce_in) begin
			pin_q_ff <= ext_trigger_pin_in;
		end
	end

	assign pin_fall = pin_q_ff && !ext_trigger_pin_in;
	assign trig_evt_out = hw_source_select_in ?
		motor_timer_evt_in : pin_fall;
endmodule

// ==== rtl/adc_fifo.sv ====
/*
 * Result FIFO with a registered output stage for the DMA side.
 * Assumes the writer honours ready; depth is a power of two.
 */
`timescale 1ns/1ps
module adc_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// write side
	stream_if.snk wr_if,
	// read side
	input wire logic rd_ready_in,
	output logic rd_valid_out,
	output logic [W-1:0] rd_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_ff [DEPTH];
	logic [AW:0] wp_ff;
	logic [AW:0] rp_ff;
	logic ov_ff;
	logic [W-1:0] od_ff;
	wire logic empty;
	wire logic full;
	wire logic push;
	wire logic load;

	assign empty = wp_ff == rp_ff;
	assign full = (wp_ff[AW] != rp_ff[AW]) &&
		(wp_ff[AW-1:0] == rp_ff[AW-1:0]);
	assign push = wr_if.valid && !full;
	assign load = !empty && (!ov_ff || rd_ready_in);
	assign wr_if.ready = !full;
	assign rd_valid_out = ov_ff;
	assign rd_data_out = od_ff;

	always_ff @(posedge mclk_in) begin
		if (ce_in && push) begin
			mem_ff[wp_ff[AW-1:0]] <= wr_if.data;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			wp_ff <= '0;
			rp_ff <= '0;
			ov_ff <= 1'b0;
			od_ff <= '0;
		end else if (ce_in) begin
			if (push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (load) begin
				od_ff <= mem_ff[rp_ff[AW-1:0]];
				rp_ff <= rp_ff + 1'b1;
				ov_ff <= 1'b1;
			end else if (rd_ready_in) begin
				ov_ff <= 1'b0;
			end
		end
	end
endmodule

// ==== rtl/adc_conversion_control.sv ====
/*
 * Conversion control of an eight-channel successive-approximation ADC:
 * triggers, timing, result placement, extended inputs and DMA stream.
 * Assumes control bits and pins are synchronous to mclk_in and that the
 * analog core presents its finished code on adc_data_in in the last
 * cycle of each conversion.
 */
// Function
// - 10-bit results fill bits 9..0, 8-bit results bits 7..0.
// - with sample-hold, conversion takes 28 cycles at 8 bit, 33 at 10.
// - software trigger starts as soon as start bit is written 1.
// - external trigger is a falling edge on the trigger pin.
// - hardware trigger is the motor timer completion event.
// - triggered start needs start bit already 1, then an event.
// - a trigger during conversion aborts and restarts from the beginning.
// - DMA mode writes every result to register zero and requests DMA.
// - extended inputs selectable only in one-shot and repeat modes.
// - field 00 none, 01 pin a, 10 pin b, 11 op-amp loop.
// - pin a result to register zero; pin b to one, zero under DMA.
// - op-amp mode routes channel out on a, converts b, own register.
// - reference connect low disconnects the ladder; DAC unaffected.
// - one-shot software trigger clears the start bit on completion.
`timescale 1ns/1ps
module adc_conversion_control
	import adc_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	// software control
	input wire logic start_wr_in,
	input wire logic start_wdata_in,
	input wire logic trigger_select_in,
	input wire logic hw_source_select_in,
	input wire logic sample_hold_enable_in,
	input wire logic res10_in,
	input wire logic [1:0] mode_in,
	input wire logic [2:0] chan_sel_in,
	input wire logic [1:0] scan_sel_in,
	input wire logic ext_input_sel_hi_in,
	input wire logic ext_input_sel_lo_in,
	input wire logic dma_mode_enable_in,
	input wire logic reference_connect_in,
	// pins, events and analog core
	input wire logic ext_trigger_pin_in,
	input wire logic motor_timer_evt_in,
	input wire logic [RES_W-1:0] adc_data_in,
	// dma side
	input wire logic dma_ready_in,
	output logic dma_req_out,
	output logic [FIFO_W-1:0] dma_data_out,
	// status and results
	output logic conversion_start_bit_out,
	output logic busy_out,
	output logic conv_done_out,
	output logic [NCH*RES_W-1:0] result_flat_out,
	// analog routing
	output logic [3:0] analog_sel_out,
	output logic ext_a_analog_out,
	output logic ext_b_analog_out,
	output logic opamp_route_out,
	output logic ladder_connect_out
);
	state_t state_ff;
	state_t nxt_state;
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [2:0] idx_ff;
	logic [2:0] nxt_idx;
	logic start_bit_ff;
	logic nxt_start;
	logic [RES_W-1:0] res_mem_ff [NCH];
	logic done_ff;
	logic busy_ff;
	logic [3:0] src_ff;
	logic ext_a_ff;
	logic ext_b_ff;
	logic opamp_ff;
	logic ladder_ff;

	wire logic trg_evt;
	wire logic ext_ok;
	wire logic [1:0] ext_field;
	wire logic [1:0] ext_mode;
	wire logic sweep;
	wire logic [2:0] last_idx;
	wire logic idx_last;
	wire logic [2:0] cur_ch;
	wire logic [3:0] src;
	wire logic [2:0] wr_idx;
	wire logic [CNT_W-1:0] last_cnt;
	wire logic at_end;
	wire logic blocked;
	wire logic restart;
	wire logic store;
	wire logic seq_end;
	wire logic auto_clr;
	wire logic done_evt;
	wire logic [RES_W-1:0] res_val;

	stream_if #(.W(FIFO_W)) push_if ();

	adc_trig_detect u_trig (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.ext_trigger_pin_in(ext_trigger_pin_in),
		.motor_timer_evt_in(motor_timer_evt_in),
		.hw_source_select_in(hw_source_select_in),
		.trig_evt_out(trg_evt)
	);

	adc_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.mclk_in(mclk_in),
		.srst_in(srst_in),
		.ce_in(ce_in),
		.wr_if(push_if),
		.rd_ready_in(dma_ready_in),
		.rd_valid_out(dma_req_out),
		.rd_data_out(dma_data_out)
	);

	// extended input decode
	assign ext_ok = (mode_in == MODE_ONESHOT) ||
		(mode_in == MODE_REPEAT);
	assign ext_field = {ext_input_sel_hi_in, ext_input_sel_lo_in};
	assign ext_mode = ext_ok ? ext_field : EXT_NONE;

	// sweep and source selection
	assign sweep = mode_in[1];
	assign last_idx = sweep ? {scan_sel_in, 1'b1} : IDX_ZERO;
	assign idx_last = idx_ff == last_idx;
	assign cur_ch = sweep ? idx_ff : chan_sel_in;
	assign src = (ext_mode == EXT_A) ? SRC_EXT_A :
		(ext_mode == EXT_NONE) ? {1'b0, cur_ch} : SRC_EXT_B;
	assign wr_idx = dma_mode_enable_in ? IDX_ZERO :
		(ext_mode == EXT_A) ? IDX_ZERO :
		(ext_mode == EXT_B) ? IDX_ONE : cur_ch;

	// conversion timing and sequencing
	assign last_cnt = conv_last(sample_hold_enable_in, res10_in);
	assign at_end = (state_ff == S_CONV) && (cnt_ff == last_cnt);
	assign blocked = dma_mode_enable_in && !push_if.ready;
	assign restart = (state_ff == S_CONV) && trigger_select_in &&
		trg_evt;
	assign store = ce_in && at_end && !restart && !blocked &&
		start_bit_ff;
	assign seq_end = store && ((mode_in == MODE_ONESHOT) ||
		((mode_in == MODE_SINGLE) && idx_last));
	assign auto_clr = seq_end && !trigger_select_in;
	assign done_evt = store && (dma_mode_enable_in ||
		(mode_in == MODE_ONESHOT) ||
		((mode_in == MODE_SINGLE) && idx_last));
	assign res_val = res10_in ? adc_data_in :
		{2'b00, adc_data_in[RES_W-1:2]};

	// dma stream
	assign push_if.valid = store && dma_mode_enable_in;
	assign push_if.data = FIFO_W'(res_val);

	// start bit: a software write wins over the automatic clear
	assign nxt_start = start_wr_in ? start_wdata_in :
		(auto_clr ? 1'b0 : start_bit_ff);

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_idx = idx_ff;
		case (state_ff)
			S_IDLE: begin
				nxt_cnt = '0;
				nxt_idx = '0;
				if (start_bit_ff && !trigger_select_in) begin
					nxt_state = S_CONV;
				end else if (start_bit_ff) begin
					nxt_state = S_WAIT;
				end
			end
			S_WAIT: begin
				if (trg_evt) begin
					nxt_state = S_CONV;
					nxt_cnt = '0;
					nxt_idx = '0;
				end
			end
			S_CONV: begin
				if (restart) begin
					nxt_cnt = '0;
					nxt_idx = '0;
				end else if (store) begin
					nxt_cnt = '0;
					nxt_idx = idx_last ? IDX_ZERO : idx_ff + IDX_ONE;
					if (seq_end && trigger_select_in) begin
						nxt_state = S_WAIT;
					end else if (seq_end) begin
						nxt_state = S_IDLE;
					end
				end else if (!at_end) begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
		if (!start_bit_ff) begin
			nxt_state = S_IDLE;
		end
	end

	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			state_ff <= S_IDLE;
			cnt_ff <= '0;
			idx_ff <= '0;
			start_bit_ff <= 1'b0;
		end else if (ce_in) begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			idx_ff <= nxt_idx;
			start_bit_ff <= nxt_start;
		end
	end

	// result registers
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_res
			always_ff @(posedge mclk_in) begin
				if (srst_in) begin
					res_mem_ff[gi] <= '0;
				end else if (store && (wr_idx == 3'(gi))) begin
					res_mem_ff[gi] <= res_val;
				end
			end
			assign result_flat_out[gi*RES_W +: RES_W] = res_mem_ff[gi];
		end
	endgenerate

	// registered status and routing
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			done_ff <= 1'b0;
			busy_ff <= 1'b0;
			src_ff <= '0;
			ext_a_ff <= 1'b0;
			ext_b_ff <= 1'b0;
			opamp_ff <= 1'b0;
			ladder_ff <= 1'b0;
		end else if (ce_in) begin
			done_ff <= done_evt;
			busy_ff <= nxt_state == S_CONV;
			src_ff <= src;
			ext_a_ff <= ext_mode == EXT_A;
			ext_b_ff <= ext_mode[1];
			opamp_ff <= ext_mode == EXT_OPAMP;
			ladder_ff <= reference_connect_in;
		end
	end

	assign conversion_start_bit_out = start_bit_ff;
	assign busy_out = busy_ff;
	assign conv_done_out = done_ff;
	assign analog_sel_out = src_ff;
	assign ext_a_analog_out = ext_a_ff;
	assign ext_b_analog_out = ext_b_ff;
	assign opamp_route_out = opamp_ff;
	assign ladder_connect_out = ladder_ff;

	// checks
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (srst_in);

	sequence s_armed_trig;
		ce_in && (state_ff == S_WAIT) && trg_evt && start_bit_ff;
	endsequence

	sequence s_fresh_conv;
		(state_ff == S_CONV) && (cnt_ff == '0) && (idx_ff == '0);
	endsequence

	a_res_narrow: assert property (
		store && !res10_in |=> res_mem_ff[$past(wr_idx)][9:8] == 2'b00)
		else $error("8-bit result has upper bits set");

	a_conv_len_sh: assert property (
		store && sample_hold_enable_in |->
		cnt_ff == (res10_in ? CYC_SH_10 : CYC_SH_8) - 6'h01)
		else $error("sample-hold conversion length wrong");

	a_sw_start: assert property (
		ce_in && (state_ff == S_IDLE) && start_bit_ff &&
		!trigger_select_in && !(start_wr_in && !start_wdata_in)
		|=> state_ff == S_CONV)
		else $error("software start did not begin conversion");

	a_pin_fall: assert property (
		ce_in && $past(ce_in) && trigger_select_in &&
		!hw_source_select_in && $fell(ext_trigger_pin_in) |-> trg_evt)
		else $error("falling edge on trigger pin missed");

	a_timer_trig: assert property (
		hw_source_select_in |-> trg_evt == motor_timer_evt_in)
		else $error("timer event not used as trigger");

	a_armed_go: assert property (
		s_armed_trig and !(start_wr_in && !start_wdata_in)
		|=> s_fresh_conv)
		else $error("armed trigger did not start conversion");

	a_no_start: assert property (
		ce_in && !start_bit_ff |=> state_ff == S_IDLE)
		else $error("converter ran without start bit");

	a_retrig: assert property (
		ce_in && restart && start_bit_ff && !start_wr_in
		|=> s_fresh_conv)
		else $error("retrigger did not restart conversion");

	a_dma_reg0: assert property (
		store && dma_mode_enable_in |-> wr_idx == IDX_ZERO && push_if.valid)
		else $error("dma result not to register zero");

	a_ext_b_reg: assert property (
		ext_ok && (ext_field == EXT_B) && !dma_mode_enable_in
		|-> wr_idx == IDX_ONE)
		else $error("pin b result misplaced");

	a_opamp_route: assert property (
		ce_in && ext_ok && (ext_field == EXT_OPAMP) |=>
		opamp_route_out && ext_b_analog_out && analog_sel_out == SRC_EXT_B)
		else $error("op-amp routing wrong");

	a_auto_clear: assert property (
		auto_clr && !start_wr_in |=> !start_bit_ff ##1 !busy_out)
		else $error("start bit not cleared after one-shot");

	a_done_pulse: assert property (
		conv_done_out && !$past(done_evt, 2) |=> !conv_done_out)
		else $error("completion pulse longer than one cycle");

	a_ladder: assert property (
		ce_in |=> ladder_connect_out == $past(reference_connect_in))
		else $error("ladder connect does not follow control");
endmodule

// ==== bench/far_side_model.sv ====
/*
 * Far side of the converter control: analog core code source and DMA sink.
 * Assumes one clock shared with the control block.
 */
`timescale 1ns/1ps
module far_side_model (
	// clock and reset
	input wire logic mclk_in,
	input wire logic srst_in,
	// control from bench and block
	input wire logic stall_in,
	input wire logic conv_done_in,
	// outputs
	output logic [9:0] adc_data_out,
	output logic dma_ready_out
);
	logic [9:0] code_ff;
	logic slow_ff;
	// new code after each finished conversion
	always_ff @(posedge mclk_in) begin
		if (srst_in) begin
			code_ff <= 10'h2A5;
			slow_ff <= 1'b0;
		end else begin
			slow_ff <= ~slow_ff;
			if (conv_done_in) begin
				code_ff <= code_ff + 10'h03B;
			end
		end
	end
	// sink takes a word every other cycle unless stalled
	assign dma_ready_out = ~stall_in & slow_ff;
	assign adc_data_out = code_ff;
endmodule

// ==== bench/adc_conversion_control_test.sv ====
/*
 * Self-checking bench for the converter control.
 * Assumes the far side model supplies codes and the DMA sink.
 */
`timescale 1ns/1ps
module adc_conversion_control_test;
	import adc_pkg::*;
	typedef struct {logic [2:0] ch; logic [15:0] val;} note_t;
	logic mclk_in = 1'b0;
	logic srst_in = 1'b1;
	logic start_wr_in = 1'b0, start_wdata_in = 1'b0, trigger_select_in = 1'b0;
	logic hw_source_select_in = 1'b0, sample_hold_enable_in = 1'b0;
	logic res10_in = 1'b0, ext_hi = 1'b0, ext_lo = 1'b0, dma_en = 1'b0;
	logic ref_in = 1'b0, pin = 1'b1, motor = 1'b0, stall = 1'b0;
	logic [1:0] mode_in = MODE_ONESHOT;
	logic ce = 1'b1;
	logic [1:0] scan = 2'h0;
	logic [2:0] ch = 3'h0;
	logic [9:0] adc_data, code = 10'h2A5;
	logic dma_ready, dma_req, start_bit, busy, done, ext_a, ext_b, opamp, ladder;
	logic [15:0] dma_data;
	logic [NCH*RES_W-1:0] results;
	logic [3:0] asel;
	logic [5:0] lens [4] = '{CYC_NOSH_8, CYC_NOSH_10, CYC_SH_8, CYC_SH_10};
	note_t notes[$];
	note_t note;
	int err_total = 0, checked = 0, n, b, m;

	always #2.5 mclk_in = ~mclk_in;

	adc_conversion_control adc_conversion_control_inst (.mclk_in(mclk_in),
		.srst_in(srst_in), .ce_in(ce), .start_wr_in(start_wr_in),
		.start_wdata_in(start_wdata_in), .trigger_select_in(trigger_select_in),
		.hw_source_select_in(hw_source_select_in),
		.sample_hold_enable_in(sample_hold_enable_in), .res10_in(res10_in),
		.mode_in(mode_in), .chan_sel_in(ch), .scan_sel_in(scan),
		.ext_input_sel_hi_in(ext_hi), .ext_input_sel_lo_in(ext_lo),
		.dma_mode_enable_in(dma_en), .reference_connect_in(ref_in),
		.ext_trigger_pin_in(pin), .motor_timer_evt_in(motor),
		.adc_data_in(adc_data), .dma_ready_in(dma_ready),
		.dma_req_out(dma_req), .dma_data_out(dma_data),
		.conversion_start_bit_out(start_bit), .busy_out(busy),
		.conv_done_out(done), .result_flat_out(results),
		.analog_sel_out(asel), .ext_a_analog_out(ext_a),
		.ext_b_analog_out(ext_b), .opamp_route_out(opamp),
		.ladder_connect_out(ladder));

	far_side_model far_side_model_inst (.mclk_in(mclk_in), .srst_in(srst_in),
		.stall_in(stall), .conv_done_in(done), .adc_data_out(adc_data),
		.dma_ready_out(dma_ready));

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge mclk_in);
		#1;
	endtask

	task automatic wr_start(input logic v);
		start_wr_in = 1'b1;
		start_wdata_in = v;
		tick(1);
		start_wr_in = 1'b0;
		tick(1);
	endtask

	// note the result of the next conversion into register r
	task automatic expect_conv(input logic [2:0] r);
		note.ch = r;
		note.val = res10_in ? {6'h00, code} : {8'h00, code[9:2]};
		notes.push_back(note);
		code = code + 10'h03B;
	endtask

	// count busy cycles until the completion pulse
	task automatic measure(input logic [7:0] want, input logic use_len);
		n = 0;
		b = 0;
		do begin
			n = busy === 1'b1 ? n + 1 : n;
			b++;
			tick(1);
		end while (done !== 1'b1 && b < 400);
		if (done !== 1'b1) begin
			err_total++;
			give_verdict();
		end
		if (use_len) begin
			chk("conv_len", 16'(n), 16'(want));
		end
	endtask

	// results seen at the ports are taken off the notes in order
	always @(posedge mclk_in) begin
		if (dma_req === 1'b1 && dma_ready === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			chk("dma_data", dma_data, note.val);
		end
		if (done === 1'b1 && dma_en === 1'b0 && notes.size() > 0) begin
			note = notes.pop_front();
			chk("result", 16'(results[note.ch*10 +: 10]), note.val);
		end
	end

	initial begin
		void'($urandom(32'h87BD));
		tick(8);
		srst_in = 1'b0;
		chk("ladder_off", 16'(ladder), 16'h0000);
		ref_in = 1'b1;
		tick(2);
		chk("ladder_on", 16'(ladder), 16'h0001);
		for (int i = 0; i < 4; i++) begin
			{sample_hold_enable_in, res10_in} = 2'(i);
			ch = 3'($urandom_range(7, 0));
			expect_conv(ch);
			wr_start(1'b1);
			measure({2'h0, lens[i]}, 1'b1);
			chk("start_clear", 16'(start_bit), 16'h0000);
		end
		$display("test timing done");
		for (int f = 1; f < 4; f++) begin
			{ext_hi, ext_lo} = 2'(f);
			ch = 3'($urandom_range(7, 0));
			expect_conv(f == 1 ? 3'h0 : (f == 2 ? 3'h1 : ch));
			wr_start(1'b1);
			tick(4);
			chk("asel", 16'(asel), f == 1 ? 16'h0008 : 16'h0009);
			chk("ext_flags", 16'({ext_a, ext_b, opamp}),
				16'({f == 1, f > 1, f == 3}));
			measure(8'h00, 1'b0);
		end
		{ext_hi, ext_lo} = 2'h0;
		$display("test extended inputs done");
		trigger_select_in = 1'b1;
		sample_hold_enable_in = 1'b1;
		res10_in = 1'b0;
		expect_conv(ch);
		wr_start(1'b1);
		tick(6);
		chk("wait_trig", 16'(busy), 16'h0000);
		fork
			begin
				pin = 1'b0;
				tick(3);
				pin = 1'b1;
				tick(7);
				pin = 1'b0;
				tick(3);
				pin = 1'b1;
			end
			measure(8'(CYC_SH_8) + 8'h0A, 1'b1);
		join
		chk("start_kept", 16'(start_bit), 16'h0001);
		wr_start(1'b0);
		hw_source_select_in = 1'b1;
		expect_conv(ch);
		wr_start(1'b1);
		fork
			begin
				motor = 1'b1;
				tick(1);
				motor = 1'b0;
			end
			measure(8'(CYC_SH_8), 1'b1);
		join
		wr_start(1'b0);
		$display("test triggers done");
		trigger_select_in = 1'b0;
		{dma_en, stall, ext_hi, mode_in} = {3'h7, MODE_REPEAT};
		repeat (18) expect_conv(3'h0);
		wr_start(1'b1);
		for (int k = 0; k < 17; k++) begin
			measure(8'(CYC_SH_8), k < 16);
		end
		tick(60);
		chk("full_stall", 16'({busy, done}), 16'h0002);
		stall = 1'b0;
		measure(8'h00, 1'b0);
		wr_start(1'b0);
		b = 0;
		while (notes.size() > 0 && b < 300) begin
			b++;
			tick(1);
		end
		chk("drained", 16'(notes.size()), 16'h0000);
		$display("test dma done");
		mode_in = MODE_SINGLE;
		scan = 2'($urandom_range(3, 0));
		m = 2 * (int'(scan) + 1);
		repeat (m) expect_conv(3'h0);
		wr_start(1'b1);
		fork
			begin
				tick(3);
				ce = 1'b0;
				tick(5);
				ce = 1'b1;
			end
			measure(8'(CYC_SH_8) + 8'h05, 1'b1);
		join
		chk("sweep_sel", 16'(asel), 16'h0000);
		chk("ext_ignored", 16'(ext_b), 16'h0000);
		for (int j = 1; j < m; j++) begin
			measure(8'(CYC_SH_8), 1'b1);
			chk("sweep_sel", 16'(asel), 16'(j));
		end
		chk("sweep_clear", 16'(start_bit), 16'h0000);
		b = 0;
		while (notes.size() > 0 && b < 300) begin
			b++;
			tick(1);
		end
		chk("swept", 16'(notes.size()), 16'h0000);
		$display("test sweep done");
		give_verdict();
	end
endmodule
